// ===== core/rss_core.v
// Remote command handler: setup store, common commands and status registers
//
// Contract
// - Recall of file 0..39 restores the settings saved under that index.
// - Save to file 0..39 writes the present settings into that slot.
// - Save may carry a label of at most 16 characters, stored with file.
// - Save without a label stores a default label.
// - Reset command returns the instrument to its reset state.
// - Trigger runs one measurement and queues its result for reading.
// - Clear-status zeroes event status; service request stays set while the operation bit and its enable bit are set.
// - Identify answers maker, model, firmware, comma separated, then newline.
// - Self-test answers the sum of error codes, zero when none.
// - Event-enable loads an 8-bit mask; its query returns it in decimal.
// - Event bits: power-on, user, command, execution, device, query, control, complete.
// - Service-request-enable loads a mask; its query returns it.
// - Status byte: 7 operation, 6 service, 5 event, 4 message; 3-0 zero.
// - Event-status query returns the register in decimal plus terminator.
// - Status byte query clears no status byte bit; bit 4 (message) is set while its answer is sent.
// - Operation-complete sets its event bit once measurements have finished.
// - Operation-complete query waits for idle, then answers '1' and terminator.
`timescale 1ns/1ps
`include "rss_map.vh"

module rss_core (
  input  wire         clk_sys,
  input  wire         sys_rst,
  // Parsed command
  input  wire         cmd_valid,
  input  wire [3:0]   cmd_code,
  input  wire [7:0]   cmd_arg,
  input  wire [4:0]   cmd_lbl_len,
  input  wire [127:0] cmd_label,
  output reg          cmd_ready_q,
  // Answer byte stream
  output reg          out_valid_q,
  output reg  [7:0]   out_data_q,
  input  wire         out_ready,
  // Instrument settings
  input  wire [31:0]  setup_cur,
  output reg          setup_load_q,
  output reg  [31:0]  setup_out_q,
  output reg          inst_rst_q,
  // Label readback
  input  wire [5:0]   lbl_rd_idx,
  output reg  [127:0] lbl_rd_q,
  // Measurement engine
  output reg          meas_start_q,
  input  wire         meas_busy,
  input  wire         meas_done,
  input  wire [7:0]   meas_result,
  // Self test
  output reg          tst_start_q,
  input  wire         tst_done,
  input  wire [7:0]   tst_err_sum,
  // Event sources
  input  wire         ev_user_req,
  input  wire         ev_cmd_err,
  input  wire         ev_exec_err,
  input  wire         ev_dev_err,
  input  wire         ev_query_err,
  input  wire         ev_req_ctl,
  input  wire         oper_summary,
  // Status
  output reg  [7:0]   status_byte_q,
  output reg          srq_q
);

  // ----------------------------------------------------------------
  // States and answer kinds
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_MEAS = 3'd1;
  localparam ST_OPCW = 3'd2;
  localparam ST_TST  = 3'd3;
  localparam ST_SEND = 3'd4;

  localparam K_DEC = 2'd0;
  localparam K_IDN = 2'd1;
  localparam K_ONE = 2'd2;

  localparam [119:0] IDN_STR = `RSS_IDN_STR;
  localparam [127:0] DEF_LBL = `RSS_DEF_LABEL;

  reg [2:0]   state_q;
  reg [1:0]   kind_q;
  reg [7:0]   val_q;
  reg [4:0]   idx_q;
  reg         esr_rd_q;
  reg         opc_set_pend_q;
  reg [7:0]   esr_q;
  reg [7:0]   ese_q;
  reg [7:0]   sre_q;
  reg [31:0]  setup_mem [0:`RSS_NFILES-1];
  reg [127:0] lbl_mem   [0:`RSS_NFILES-1];

  // ----------------------------------------------------------------
  // Answer byte generator: returns {last, char}
  // ----------------------------------------------------------------
  function [8:0] resp_char;
    input [1:0] kind;
    input [7:0] val;
    input [4:0] idx;
    reg   [4:0] pos;
    reg   [7:0] hun;
    reg   [7:0] ten;
    reg   [7:0] one;
    begin
      hun = val / 8'd100;
      ten = (val / 8'd10) % 8'd10;
      one = val % 8'd10;
      pos = idx;
      resp_char = {1'b1, `RSS_ASC_NL};
      case (kind)
        K_DEC: begin
          if (val < 8'd10) begin
            pos = idx + 5'd2;
          end else if (val < 8'd100) begin
            pos = idx + 5'd1;
          end
          case (pos)
            5'd0:    resp_char = {1'b0, `RSS_ASC_ZERO + hun};
            5'd1:    resp_char = {1'b0, `RSS_ASC_ZERO + ten};
            5'd2:    resp_char = {1'b0, `RSS_ASC_ZERO + one};
            default: resp_char = {1'b1, `RSS_ASC_NL};
          endcase
        end
        K_IDN: begin
          resp_char = {(idx == `RSS_IDN_LEN - 5'd1), IDN_STR[8*(14-idx) +: 8]};
        end
        K_ONE: begin
          if (idx == 5'd0) begin
            resp_char = {1'b0, `RSS_ASC_ONE};
          end
        end
        default: resp_char = {1'b1, `RSS_ASC_NL};
      endcase
    end
  endfunction

  wire [8:0] cur_char = resp_char(kind_q, val_q, idx_q);
  wire       file_ok  = (cmd_arg[7:6] == 2'b00) && (cmd_arg[5:0] <= `RSS_LAST_FILE);
  wire       take     = cmd_valid && cmd_ready_q;
  wire       last_out = out_valid_q && out_ready && cur_char[8];

  // ----------------------------------------------------------------
  // Label composition: short or missing labels are padded
  // ----------------------------------------------------------------
  wire [127:0] lbl_new;
  genvar gi;
  generate
    for (gi = 0; gi < `RSS_LBL_CHARS; gi = gi + 1) begin : g_lbl
      assign lbl_new[127-8*gi -: 8] =
        (cmd_lbl_len == 5'd0) ? DEF_LBL[127-8*gi -: 8] :
        (gi < cmd_lbl_len)    ? cmd_label[127-8*gi -: 8] :
                                `RSS_ASC_SPACE;
    end
  endgenerate

  // ----------------------------------------------------------------
  // File store; no reset since contents are user data
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (take && cmd_code == `RSS_CMD_SAVE && file_ok) begin
      setup_mem[cmd_arg[5:0]] <= setup_cur;
      lbl_mem[cmd_arg[5:0]]   <= lbl_new;
    end
    lbl_rd_q <= (lbl_rd_idx <= `RSS_LAST_FILE) ? lbl_mem[lbl_rd_idx] : 128'h0;
  end

  // ----------------------------------------------------------------
  // Event status: hardware sets win over any clear in the same cycle
  // ----------------------------------------------------------------
  wire bad_file = take && (cmd_code == `RSS_CMD_RECALL || cmd_code == `RSS_CMD_SAVE)
                  && !file_ok;
  wire bad_len  = take && cmd_code == `RSS_CMD_SAVE && cmd_lbl_len > 5'd16;
  wire opc_fire = opc_set_pend_q && !meas_busy && state_q != ST_MEAS;
  wire [7:0] ev_set;
  assign ev_set[`RSS_EV_PON] = 1'b0;
  assign ev_set[`RSS_EV_URQ] = ev_user_req;
  assign ev_set[`RSS_EV_CME] = ev_cmd_err || bad_len;
  assign ev_set[`RSS_EV_EXE] = ev_exec_err || bad_file;
  assign ev_set[`RSS_EV_DDE] = ev_dev_err;
  assign ev_set[`RSS_EV_QYE] = ev_query_err;
  assign ev_set[`RSS_EV_RQC] = ev_req_ctl;
  assign ev_set[`RSS_EV_OPC] = opc_fire;

  wire esr_clr = (take && cmd_code == `RSS_CMD_CLS) || (esr_rd_q && last_out);

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      esr_q          <= `RSS_ESR_RST;
      opc_set_pend_q <= 1'b0;
    end else begin
      esr_q <= (esr_clr ? 8'h00 : esr_q) | ev_set;
      if (take && cmd_code == `RSS_CMD_OPC) begin
        opc_set_pend_q <= 1'b1;
      end else if (opc_fire) begin
        opc_set_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status byte and service request
  // ----------------------------------------------------------------
  wire       esb    = |(esr_q & ese_q);
  wire       mav    = (state_q == ST_SEND);
  wire [7:0] sb_raw = {oper_summary, 1'b0, esb, mav, 4'h0};
  wire       rqs    = |(sb_raw & sre_q);

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_byte_q <= 8'h00;
      srq_q         <= 1'b0;
    end else begin
      status_byte_q <= {sb_raw[7], rqs, sb_raw[5:4], 4'h0};
      srq_q         <= rqs;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q      <= ST_IDLE;
      kind_q       <= K_DEC;
      val_q        <= 8'h00;
      idx_q        <= 5'd0;
      esr_rd_q     <= 1'b0;
      ese_q        <= `RSS_ESE_RST;
      sre_q        <= `RSS_SRE_RST;
      cmd_ready_q  <= 1'b1;
      out_valid_q  <= 1'b0;
      out_data_q   <= 8'h00;
      setup_load_q <= 1'b0;
      setup_out_q  <= 32'h0;
      inst_rst_q   <= 1'b0;
      meas_start_q <= 1'b0;
      tst_start_q  <= 1'b0;
    end else begin
      setup_load_q <= 1'b0;
      inst_rst_q   <= 1'b0;
      meas_start_q <= 1'b0;
      tst_start_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          idx_q    <= 5'd0;
          esr_rd_q <= 1'b0;
          if (take) begin
            case (cmd_code)
              `RSS_CMD_RECALL: begin
                if (file_ok) begin
                  setup_out_q  <= setup_mem[cmd_arg[5:0]];
                  setup_load_q <= 1'b1;
                end
              end
              `RSS_CMD_RST: begin
                inst_rst_q <= 1'b1;
              end
              `RSS_CMD_TRG: begin
                meas_start_q <= 1'b1;
                cmd_ready_q  <= 1'b0;
                state_q      <= ST_MEAS;
              end
              `RSS_CMD_IDN_Q: begin
                kind_q      <= K_IDN;
                cmd_ready_q <= 1'b0;
                state_q     <= ST_SEND;
              end
              `RSS_CMD_TST_Q: begin
                tst_start_q <= 1'b1;
                cmd_ready_q <= 1'b0;
                state_q     <= ST_TST;
              end
              `RSS_CMD_ESE: begin
                ese_q <= cmd_arg;
              end
              `RSS_CMD_SRE: begin
                sre_q <= cmd_arg;
              end
              `RSS_CMD_ESE_Q, `RSS_CMD_SRE_Q, `RSS_CMD_ESR_Q, `RSS_CMD_STB_Q: begin
                kind_q      <= K_DEC;
                cmd_ready_q <= 1'b0;
                state_q     <= ST_SEND;
                esr_rd_q    <= (cmd_code == `RSS_CMD_ESR_Q);
                case (cmd_code)
                  `RSS_CMD_ESE_Q: val_q <= ese_q;
                  `RSS_CMD_SRE_Q: val_q <= sre_q;
                  `RSS_CMD_ESR_Q: val_q <= esr_q;
                  default:        val_q <= status_byte_q;
                endcase
              end
              `RSS_CMD_OPC_Q: begin
                kind_q      <= K_ONE;
                cmd_ready_q <= 1'b0;
                state_q     <= ST_OPCW;
              end
              default: begin
                cmd_ready_q <= 1'b1;
              end
            endcase
          end
        end
        ST_MEAS: begin
          if (meas_done) begin
            val_q   <= meas_result;
            kind_q  <= K_DEC;
            state_q <= ST_SEND;
          end
        end
        ST_OPCW: begin
          // Answer only once the measurement engine is idle
          if (!meas_busy) begin
            state_q <= ST_SEND;
          end
        end
        ST_TST: begin
          if (tst_done) begin
            val_q   <= tst_err_sum;
            kind_q  <= K_DEC;
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (!out_valid_q) begin
            out_valid_q <= 1'b1;
            out_data_q  <= cur_char[7:0];
          end else if (out_ready) begin
            out_valid_q <= 1'b0;
            idx_q       <= idx_q + 5'd1;
            if (cur_char[8]) begin
              state_q     <= ST_IDLE;
              cmd_ready_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q     <= ST_IDLE;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ===== core/rss_map.vh
// Constants for the remote status and setup store command handler
`ifndef RSS_MAP_VH
`define RSS_MAP_VH

// Command codes on cmd_code
`define RSS_CMD_RECALL   4'h0
`define RSS_CMD_SAVE     4'h1
`define RSS_CMD_RST      4'h2
`define RSS_CMD_TRG      4'h3
`define RSS_CMD_CLS      4'h4
`define RSS_CMD_IDN_Q    4'h5
`define RSS_CMD_TST_Q    4'h6
`define RSS_CMD_ESE      4'h7
`define RSS_CMD_ESE_Q    4'h8
`define RSS_CMD_SRE      4'h9
`define RSS_CMD_SRE_Q    4'ha
`define RSS_CMD_ESR_Q    4'hb
`define RSS_CMD_STB_Q    4'hc
`define RSS_CMD_OPC      4'hd
`define RSS_CMD_OPC_Q    4'he

// Setup file store
`define RSS_NFILES       40
`define RSS_LAST_FILE    6'h27
`define RSS_LBL_CHARS    16
`define RSS_SET_W        32

// Standard event status bit positions
`define RSS_EV_PON       7
`define RSS_EV_URQ       6
`define RSS_EV_CME       5
`define RSS_EV_EXE       4
`define RSS_EV_DDE       3
`define RSS_EV_QYE       2
`define RSS_EV_RQC       1
`define RSS_EV_OPC       0

// Status byte bit positions
`define RSS_SB_OSS       7
`define RSS_SB_RQS       6
`define RSS_SB_ESB       5
`define RSS_SB_MAV       4

// Reset values
`define RSS_ESR_RST      8'h80
`define RSS_ESE_RST      8'h00
`define RSS_SRE_RST      8'h00

// ASCII
`define RSS_ASC_NL       8'h0a
`define RSS_ASC_ONE      8'h31
`define RSS_ASC_ZERO     8'h30
`define RSS_ASC_SPACE    8'h20

// Default label "SETUP" padded with spaces; identity string is arbitrary
`define RSS_DEF_LABEL    128'h53455455502020202020202020202020
`define RSS_IDN_LEN      5'd15
`define RSS_IDN_STR      120'h4d414b45522c4d4f44454c2c56300a

`endif

// ===== test/rss_core_tb.sv
// Self-checking bench for the command handler
`timescale 1ns/1ps
`include "rss_map.vh"
module rss_core_tb;
  reg          clk_sys = 1'b0;
  reg          sys_rst = 1'b1;
  reg          cmd_valid = 1'b0;
  reg  [3:0]   cmd_code = 4'h0;
  reg  [7:0]   cmd_arg = 8'h00;
  reg  [4:0]   cmd_lbl_len = 5'h00;
  reg  [127:0] cmd_label = 128'h0;
  reg          out_ready = 1'b1;
  reg  [31:0]  setup_cur = 32'h0;
  reg  [5:0]   lbl_rd_idx = 6'h00;
  reg  [5:0]   ev = 6'h00;
  reg          oper_summary = 1'b0;
  reg          hold = 1'b0;
  reg  [7:0]   res = 8'h00;
  reg  [7:0]   err = 8'h00;
  wire         cmd_ready_q, out_valid_q, setup_load_q, inst_rst_q, meas_start_q;
  wire         meas_busy, meas_done, tst_start_q, tst_done, srq_q;
  wire [7:0]   out_data_q, meas_result, tst_err_sum, status_byte_q;
  wire [31:0]  setup_out_q;
  wire [127:0] lbl_rd_q;
  integer      err_count = 0;
  integer      checked = 0;
  integer      rst_seen = 0;
  integer      i;
  reg  [7:0]   m;
  reg  [31:0]  loaded = 32'h0;
  reg  [127:0] s;

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (inst_rst_q)
      rst_seen = rst_seen + 1;
    if (setup_load_q)
      loaded = setup_out_q;
  end

  rss_core u_dut (.clk_sys, .sys_rst, .cmd_valid, .cmd_code, .cmd_arg, .cmd_lbl_len,
    .cmd_label, .cmd_ready_q, .out_valid_q, .out_data_q, .out_ready, .setup_cur,
    .setup_load_q, .setup_out_q, .inst_rst_q, .lbl_rd_idx, .lbl_rd_q, .meas_start_q,
    .meas_busy, .meas_done, .meas_result, .tst_start_q, .tst_done, .tst_err_sum,
    .ev_user_req(ev[5]), .ev_cmd_err(ev[4]), .ev_exec_err(ev[3]), .ev_dev_err(ev[2]),
    .ev_query_err(ev[1]), .ev_req_ctl(ev[0]), .oper_summary, .status_byte_q, .srq_q);

  rss_meas_model u_meas (.clk_sys, .sys_rst, .meas_start_q, .tst_start_q, .hold, .res,
    .err, .meas_busy, .meas_done, .meas_result, .tst_done, .tst_err_sum);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task results;
    begin
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input [127:0] got, input [127:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  task tmo;
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t wait ran out", $time);
      results;
    end
  endtask

  // Decimal text with no leading zeros, newline last
  // Digits kept at 8 bits so the concatenation stays byte aligned
  function [127:0] dec(input [7:0] v);
    reg [7:0] h;
    reg [7:0] t;
    reg [7:0] o;
    begin
      h = 8'h30 + v / 8'd100;
      t = 8'h30 + (v / 8'd10) % 8'd10;
      o = 8'h30 + v % 8'd10;
      if (v >= 8'h64)
        dec = {96'h0, h, t, o, 8'h0a};
      else if (v >= 8'h0a)
        dec = {104'h0, t, o, 8'h0a};
      else
        dec = {112'h0, o, 8'h0a};
    end
  endfunction

  // Request held until the edge that sees ready, then one idle edge
  task cmd(input [3:0] c, input [7:0] a, input [4:0] l);
    integer n;
    begin
      cmd_code <= c;
      cmd_arg <= a;
      cmd_lbl_len <= l;
      cmd_valid <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (!cmd_ready_q && n < 100) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      cmd_valid <= 1'b0;
      if (n == 100)
        tmo;
      @(posedge clk_sys);
    end
  endtask

  // Collects answer bytes up to newline, stalling the first cycles
  task rx;
    integer n;
    begin
      s = 128'h0;
      out_ready <= 1'b0;
      repeat (3) @(posedge clk_sys);
      out_ready <= 1'b1;
      n = 0;
      while (n < 400) begin
        @(posedge clk_sys);
        if (out_valid_q && out_ready) begin
          s = {s[119:0], out_data_q};
          if (out_data_q == 8'h0a)
            n = 999;
        end
        n = n + 1;
      end
      if (n < 999)
        tmo;
    end
  endtask

  task q(input [3:0] c);
    begin
      cmd(c, 8'h00, 5'h00);
      rx;
    end
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h80));
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h00));
    for (i = 0; i < 3; i = i + 1) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'h25 : 8'hff;
      cmd(`RSS_CMD_ESE, m, 5'h00);
      q(`RSS_CMD_ESE_Q);
      chk(s, dec(m));
      cmd(`RSS_CMD_SRE, m, 5'h00);
      q(`RSS_CMD_SRE_Q);
      chk(s, dec(m));
    end
    for (i = 0; i < 6; i = i + 1) begin
      ev <= 6'h01 << i;
      @(posedge clk_sys);
      ev <= 6'h00;
      @(posedge clk_sys);
    end
    oper_summary <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(status_byte_q[5], 1'b1);
    chk(srq_q, 1'b1);
    q(`RSS_CMD_STB_Q);
    chk(s, dec(8'he0));
    repeat (2) @(posedge clk_sys);
    chk(status_byte_q, 8'he0);
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h7e));
    ev <= 6'h20;
    @(posedge clk_sys);
    ev <= 6'h00;
    oper_summary <= 1'b0;
    cmd(`RSS_CMD_CLS, 8'h00, 5'h00);
    repeat (3) @(posedge clk_sys);
    chk(status_byte_q, 8'h00);
    chk(srq_q, 1'b0);
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h00));
    setup_cur <= 32'h1234abcd;
    cmd(`RSS_CMD_SAVE, 8'h00, 5'h00);
    setup_cur <= 32'h5a5a0f0f;
    cmd_label <= 128'h4142434445464748494a4b4c4d4e4f50;
    cmd(`RSS_CMD_SAVE, 8'h27, 5'h10);
    cmd(`RSS_CMD_RECALL, 8'h27, 5'h00);
    repeat (3) @(posedge clk_sys);
    chk(loaded, 32'h5a5a0f0f);
    cmd(`RSS_CMD_RECALL, 8'h00, 5'h00);
    repeat (3) @(posedge clk_sys);
    chk(loaded, 32'h1234abcd);
    lbl_rd_idx <= 6'h27;
    repeat (2) @(posedge clk_sys);
    chk(lbl_rd_q, 128'h4142434445464748494a4b4c4d4e4f50);
    lbl_rd_idx <= 6'h00;
    repeat (2) @(posedge clk_sys);
    chk(lbl_rd_q, `RSS_DEF_LABEL);
    cmd(`RSS_CMD_SAVE, 8'h28, 5'h00);
    cmd(`RSS_CMD_SAVE, 8'h05, 5'h11);
    cmd(`RSS_CMD_RECALL, 8'h28, 5'h00);
    repeat (3) @(posedge clk_sys);
    chk(loaded, 32'h1234abcd);
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h30));
    cmd(`RSS_CMD_RST, 8'h00, 5'h00);
    repeat (3) @(posedge clk_sys);
    chk(rst_seen, 1);
    res <= 8'hc8;
    q(`RSS_CMD_TRG);
    chk(s, dec(8'hc8));
    q(`RSS_CMD_TST_Q);
    chk(s, dec(8'h00));
    err <= 8'h07;
    q(`RSS_CMD_TST_Q);
    chk(s, dec(8'h07));
    q(`RSS_CMD_IDN_Q);
    chk(s, `RSS_IDN_STR);
    hold <= 1'b1;
    cmd(`RSS_CMD_OPC_Q, 8'h00, 5'h00);
    repeat (8) @(posedge clk_sys);
    chk(out_valid_q, 1'b0);
    hold <= 1'b0;
    rx;
    chk(s, 16'h310a);
    q(`RSS_CMD_OPC_Q);
    chk(s, 16'h310a);
    hold <= 1'b1;
    cmd(`RSS_CMD_OPC, 8'h00, 5'h00);
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h00));
    hold <= 1'b0;
    repeat (3) @(posedge clk_sys);
    q(`RSS_CMD_ESR_Q);
    chk(s, dec(8'h01));
    results;
  end
endmodule

// ===== test/rss_meas_model.sv
// Measurement engine and self-test model facing the command handler
`timescale 1ns/1ps
module rss_meas_model (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       meas_start_q,
  input  wire       tst_start_q,
  input  wire       hold,
  input  wire [7:0] res,
  input  wire [7:0] err,
  output wire       meas_busy,
  output reg        meas_done,
  output wire [7:0] meas_result,
  output reg        tst_done,
  output wire [7:0] tst_err_sum
);
  reg [3:0] cnt_q;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      meas_done <= 1'b0;
      tst_done <= 1'b0;
    end else begin
      meas_done <= (cnt_q == 4'h1);
      tst_done <= tst_start_q;
      if (meas_start_q)
        cnt_q <= 4'h6;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end

  // Hold lets the bench keep an operation pending without a trigger
  assign meas_busy = hold | (cnt_q != 4'h0);
  // Result lines carry junk outside the done pulse
  assign meas_result = meas_done ? res : ~res;
  assign tst_err_sum = tst_done ? err : ~err;
endmodule

// ===== test/rss_props.sv
// Port-level assertions for the command handler
`timescale 1ns/1ps
`include "rss_map.vh"
module rss_props (
  input wire       clk_sys,
  input wire       sys_rst,
  input wire       cmd_valid,
  input wire [3:0] cmd_code,
  input wire [7:0] cmd_arg,
  input wire       cmd_ready_q,
  input wire       out_valid_q,
  input wire [7:0] out_data_q,
  input wire       out_ready,
  input wire       setup_load_q,
  input wire       inst_rst_q,
  input wire       meas_start_q,
  input wire       meas_busy,
  input wire       tst_start_q,
  input wire [7:0] status_byte_q
);
  wire tk = cmd_valid && cmd_ready_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  stb_low_zero_a:
    assert property (status_byte_q[3:0] == 4'h0) else $error("status byte low bits set");
  rst_pulse_a:
    assert property (tk && cmd_code == `RSS_CMD_RST |-> ##[1:2] inst_rst_q ##1 !inst_rst_q)
    else $error("reset pulse missing");
  trig_start_a:
    assert property (tk && cmd_code == `RSS_CMD_TRG |-> ##[1:2] meas_start_q)
    else $error("trigger start missing");
  test_start_a:
    assert property (tk && cmd_code == `RSS_CMD_TST_Q |-> ##[1:2] tst_start_q)
    else $error("self test start missing");
  recall_ok_a:
    assert property (tk && cmd_code == `RSS_CMD_RECALL && cmd_arg <= 8'h27
      |-> ##[1:2] setup_load_q) else $error("recall load missing");
  recall_bad_a:
    assert property (tk && cmd_code == `RSS_CMD_RECALL && cmd_arg > 8'h27
      |=> !setup_load_q [*2]) else $error("bad index loaded");
  answer_hold_a:
    assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
    else $error("answer byte dropped");
  busy_answer_a:
    assert property (out_valid_q |-> !cmd_ready_q) else $error("ready during answer");
  opc_answer_a:
    assert property (tk && cmd_code == `RSS_CMD_OPC_Q && !meas_busy
      |-> ##3 out_valid_q && out_data_q == `RSS_ASC_ONE) else $error("opc answer wrong");

  cover property (tk && cmd_code == `RSS_CMD_SAVE);
  cover property (out_valid_q && out_ready && out_data_q == `RSS_ASC_NL);
  cover property (meas_busy && !cmd_ready_q && !out_valid_q);
endmodule

bind rss_core rss_props u_props (.clk_sys, .sys_rst, .cmd_valid, .cmd_code, .cmd_arg,
  .cmd_ready_q, .out_valid_q, .out_data_q, .out_ready, .setup_load_q, .inst_rst_q,
  .meas_start_q, .meas_busy, .tst_start_q, .status_byte_q);
